// ==== bench/adcrg_pin_model.sv ====
// bench: model of the four general-purpose pins and what hangs on them
`default_nettype none
module adcrg_pin_model (
    // clock
    input wire logic clk,
    // device side
    input wire logic [3:0] gp_out,
    input wire logic [3:0] gp_oe,
    // pin levels seen by the device
    output logic [3:0] gp_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] last_q = 4'h0;
    // undriven pins have no pull: show the inverse of the last level, so a
    // stale value can never pass for a driven one
    assign gp_in = (gp_oe & gp_out) | (~gp_oe & ~last_q);
    always @(posedge clk) begin
        // remember only driven levels, so a floating pin stays steady
        last_q <= (gp_oe & gp_out) | (~gp_oe & last_q);
    end
endmodule : adcrg_pin_model
`default_nettype wire

// ==== bench/tb_adcrg_regs.sv ====
// bench: self-checking testbench of the converter register bank
`default_nettype none
module tb_adcrg_regs;
    timeunit 1ns;
    timeprecision 1ns;
    import adcrg_pkg::*;
    logic clk = 0, reset = 1, clk_en = 1, reg_wr = 0, reg_rd = 0;
    logic result_valid = 0, cal_done = 0;
    logic [2:0] reg_addr = 0;
    logic [31:0] reg_wdata = 0, reg_rdata, d;
    logic [23:0] result_value = 0, cal_coeff = 0, active_offset;
    logic [9:0] chan_en = 10'h001;
    logic [2:0] active_pair;
    logic data_ready_n, bridge_switch_on, second_reference_input;
    logic [3:0] gp_in, gp_out, gp_oe;
    int miscompares = 0, check_count = 0;
    localparam logic [7:0] TB_ID = 8'h5A; // arbitrary identity value
    adcrg_regs #(.ID_CODE(TB_ID)) i_adcrg_regs (.clk(clk), .reset(reset), .clk_en(clk_en),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .result_valid(result_valid), .result_value(result_value), .chan_en(chan_en),
        .cal_done(cal_done), .cal_coeff(cal_coeff), .active_pair(active_pair),
        .active_offset(active_offset), .data_ready_n(data_ready_n),
        .bridge_switch_on(bridge_switch_on), .gp_in(gp_in), .gp_out(gp_out), .gp_oe(gp_oe),
        .second_reference_input(second_reference_input));
    adcrg_pin_model i_adcrg_pin_model (.clk(clk), .gp_out(gp_out), .gp_oe(gp_oe), .gp_in(gp_in));
    // 20 MHz clock
    initial begin
        forever #25 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////////////
    // shared compare and register port tasks
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [2:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr
    // read data stand only in the cycle after the strobe, so sample just then
    task automatic rd(input logic [2:0] a, output logic [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd
    task automatic rchk(input string what, input logic [2:0] a, input logic [31:0] exp);
        rd(a, d);
        chk(what, exp, d);
    endtask : rchk
    ////////////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset();
        chk("ready pin", 1, data_ready_n);
        rchk("data rst", ADCRG_SEL_DATA, 0);
        rchk("id", ADCRG_SEL_ID, {24'h00_0000, TB_ID});
        rchk("gpo rst", ADCRG_SEL_GPO, 0);
        rchk("ofs rst", ADCRG_SEL_OFFSET, 32'h0080_0000);
        chk("oe rst", 0, gp_oe);
    endtask : t_reset
    task automatic t_readonly();
        wr(ADCRG_SEL_DATA, 32'hffff_ffff);
        wr(ADCRG_SEL_ID, 32'h0000_0000);
        rchk("data ro", ADCRG_SEL_DATA, 0);
        rchk("id ro", ADCRG_SEL_ID, {24'h00_0000, TB_ID});
    endtask : t_readonly
    // top bit is always written as zero by this host
    task automatic t_gpo();
        wr(ADCRG_SEL_GPO, 32'h0000_007f);
        chk("bridge", 1, bridge_switch_on);
        chk("oe all", 4'hf, gp_oe);
        chk("out all", 4'hf, gp_out);
        repeat (3) @(posedge clk);
        rchk("gpo rb", ADCRG_SEL_GPO, 32'h0000_007f);
        wr(ADCRG_SEL_GPO, 32'h0000_003a);
        chk("bridge off", 0, bridge_switch_on);
        chk("out a", 4'ha, gp_out);
        repeat (3) @(posedge clk);
        rchk("gpo rb a", ADCRG_SEL_GPO, 32'h0000_003a);
        wr(ADCRG_SEL_GPO, 32'h0000_0025);
        chk("oe upper", 4'hc, gp_oe);
        chk("out upper", 4'h4, gp_out);
        wr(ADCRG_SEL_GPO, 32'h0000_0030);
        wr(ADCRG_SEL_CTRL, 32'h0000_0002);
        chk("ref sel", 1, second_reference_input);
        chk("oe ref", 4'hc, gp_oe);
        // released lower pins float to the inverse of their last driven zero
        repeat (3) @(posedge clk);
        rchk("gpo rb pin", ADCRG_SEL_GPO, 32'h0000_0033);
    endtask : t_gpo
    // with the clock enable low a write must leave everything as it was
    task automatic t_freeze();
        @(posedge clk);
        clk_en <= 1'b0;
        wr(ADCRG_SEL_GPO, 32'h0000_0040);
        @(posedge clk);
        clk_en <= 1'b1;
        #1 chk("frozen bridge", 0, bridge_switch_on);
        chk("frozen oe", 4'hf, gp_oe);
    endtask : t_freeze
    // every enable in pseudo mode, result read with status appended
    task automatic t_chan();
        logic [23:0] v;
        wr(ADCRG_SEL_CTRL, 32'h0000_0005);
        for (int i = 0; i < 10; i++) begin
            v = 24'h12_3400 + 24'(i);
            @(posedge clk);
            chan_en <= 10'(1 << i);
            result_valid <= 1'b1;
            result_value <= v;
            @(posedge clk);
            result_valid <= 1'b0;
            #1 chk("ready low", 0, data_ready_n);
            if (i != 8) chk("pair", (i < 4) ? i : (i < 8) ? 4 : 0, active_pair);
            rchk("data sta", ADCRG_SEL_DATA, {v, 8'(i)});
            chk("ready high", 1, data_ready_n);
        end
    endtask : t_chan
    // converter kept idle (no result pulses) while offsets are written
    task automatic t_offset();
        for (int p = 0; p < 5; p++) begin
            wr(ADCRG_SEL_OFFSET, {5'h0, 3'(p), 24'h11_1111 * 24'(p + 1)});
        end
        for (int p = 0; p < 5; p++) begin
            @(posedge clk);
            chan_en <= 10'(1 << p);
            @(posedge clk);
            #1 chk("ofs pair", 24'h11_1111 * 24'(p + 1), active_offset);
        end
        rchk("ofs rd", ADCRG_SEL_OFFSET, 32'h0455_5555);
        @(posedge clk);
        chan_en <= 10'h002;
        cal_done <= 1'b1;
        cal_coeff <= 24'hab_cdef;
        @(posedge clk);
        cal_done <= 1'b0;
        #1 chk("cal ofs", 24'hab_cdef, active_offset);
        wr(ADCRG_SEL_CTRL, 32'h0000_0000);
        @(posedge clk);
        chan_en <= 10'h020;
        @(posedge clk);
        #1 chk("diff pair", 24'hab_cdef, active_offset);
    endtask : t_offset
    ////////////////////////////////////////////////////////////////////////////////////
    // verdict and run control
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done
    initial begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        t_reset();
        t_readonly();
        t_gpo();
        t_chan();
        t_offset();
        t_freeze();
        test_done();
    end
    // the sequence needs about 130 cycles; far beyond that means a hang
    initial begin
        #200_000;
        miscompares++;
        test_done();
    end
endmodule : tb_adcrg_regs
`default_nettype wire

// ==== hw/adcrg_chan_map.sv ====
// module: channel enable to channel code and calibration pair mapping
`default_nettype none
module adcrg_chan_map
    import adcrg_pkg::*;
(
    // selection
    input wire logic [9:0] chan_en,
    input wire logic pseudo,
    // mapped results
    output logic [3:0] channel_code,
    output logic [2:0] cal_pair,
    output logic valid
);
    // lowest set enable wins; a single enable is the documented use
    function automatic logic [3:0] first_set(input logic [9:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 9; i >= 0; i--) begin
            if (v[i]) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction : first_set

    wire logic [3:0] idx = first_set(chan_en);
    wire logic is_short = (idx == 4'(ADCRG_SHORT_BIT));
    wire logic is_temp = (idx == 4'(ADCRG_TEMP_BIT));
    // channel codes follow the enable index directly
    assign channel_code = is_short ? ADCRG_CODE_SHORT : (is_temp ? ADCRG_CODE_TEMP : idx);
    // pseudo mode shares pair 4 for upper channels; differential folds to 0..3
    assign cal_pair = is_short ? 3'h0 :
                      (pseudo && idx[2]) ? ADCRG_PAIR_SHARED : {1'b0, idx[1:0]};
    assign valid = |chan_en;
endmodule : adcrg_chan_map
`default_nettype wire

// ==== hw/adcrg_regs.sv ====
// module: converter register bank with result, identity, output control and offsets
`default_nettype none
// Functional notes
// - pseudo enables map to channel codes
// - pseudo channels four-seven share calibration pair four
// - data register is 24-bit read-only
// - data read sets ready, no unread result
// - append status after result when enabled
// - status low nibble holds channel code
// - identity register read-only, returns code
// - output control 8-bit, resets zero
// - bit six drives bridge switch
// - upper enable drives outputs three, two
// - lower enable drives outputs one, zero
// - data bits set enabled pin levels
// - readback shows actual enabled pin levels
// - lower pins serve as second reference
// - offsets 24-bit, reset 0x800000
// - five offset registers paired with full-scale; this bank holds the five offsets only, with no full-scale registers
// - zero-scale calibration overwrites selected offset
// - register select codes, data resets zero
module adcrg_regs
    import adcrg_pkg::*;
#(
    parameter logic [7:0] ID_CODE = 8'h5A // arbitrary identity value
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    // register port
    input wire logic [2:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // converter side
    input wire logic result_valid,
    input wire logic [23:0] result_value,
    input wire logic [9:0] chan_en,
    input wire logic cal_done,
    input wire logic [23:0] cal_coeff,
    // calibration lookup
    output logic [2:0] active_pair,
    output logic [23:0] active_offset,
    // pins
    output logic data_ready_n,
    output logic bridge_switch_on,
    input wire logic [3:0] gp_in,
    output logic [3:0] gp_out,
    output logic [3:0] gp_oe,
    output logic second_reference_input
);
    ////////////////////////////////////////////////////////////////////////
    // state
    adcrg_result_t result_q;
    logic nrdy_q;
    logic [7:0] gpo_q;
    logic [7:0] ctrl_q;
    logic [23:0] offset_q [ADCRG_NPAIR];
    logic [2:0] offset_sel_q;
    logic [31:0] rdata_q;
    logic [3:0] gp_s1_q;
    logic [3:0] gp_s2_q;

    logic [3:0] map_code;
    logic [2:0] map_pair;

    adcrg_chan_map i_adcrg_chan_map (
        .chan_en(chan_en),
        .pseudo(ctrl_q[ADCRG_CTL_PSEUDO]),
        .channel_code(map_code),
        .cal_pair(map_pair),
        .valid()
    );

    ////////////////////////////////////////////////////////////////////////
    // decode
    wire logic wr_gpo = reg_wr && (reg_addr == ADCRG_SEL_GPO);
    wire logic wr_ctrl = reg_wr && (reg_addr == ADCRG_SEL_CTRL);
    wire logic wr_off = reg_wr && (reg_addr == ADCRG_SEL_OFFSET);
    wire logic rd_data = reg_rd && (reg_addr == ADCRG_SEL_DATA);
    wire logic up_en = gpo_q[ADCRG_GPO_UPEN];
    wire logic lo_en = gpo_q[ADCRG_GPO_LOEN];
    wire logic [7:0] status = {nrdy_q, 3'h0, result_q.code};
    wire logic [2:0] wr_pair = (reg_wdata[26:24] < 3'(ADCRG_NPAIR)) ? reg_wdata[26:24] : 3'h0;
    // readback of one pin pair: synchronised pin level when enabled, stored bit otherwise
    function automatic logic [1:0] pin_view(input logic en, input logic [1:0] pin,
                                            input logic [1:0] dat);
        return en ? pin : dat;
    endfunction : pin_view

    // drive value of one pin pair; a disabled pair never leaks its data bits
    function automatic logic [1:0] pair_drive(input logic en, input logic [1:0] dat);
        return en ? dat : 2'b00;
    endfunction : pair_drive

    // pin levels replace data bits while the pair is enabled
    wire logic [7:0] gpo_read = {gpo_q[7:4],
                                 pin_view(up_en, gp_s2_q[3:2], gpo_q[3:2]),
                                 pin_view(lo_en, gp_s2_q[1:0], gpo_q[1:0])};
    // status rides in the low byte behind the 24-bit result
    wire logic [31:0] data_read = ctrl_q[ADCRG_CTL_APPEND] ?
                                  {result_q.value, status} : {8'h00, result_q.value};
    logic [31:0] rd_mux;
    always_comb begin
        case (reg_addr)
            ADCRG_SEL_DATA: rd_mux = data_read;
            ADCRG_SEL_ID: rd_mux = {24'h00_0000, ID_CODE};
            ADCRG_SEL_GPO: rd_mux = {24'h00_0000, gpo_read};
            ADCRG_SEL_OFFSET: rd_mux = {5'h00, offset_sel_q, offset_q[offset_sel_q]};
            ADCRG_SEL_CTRL: rd_mux = {24'h00_0000, ctrl_q};
            ADCRG_SEL_STATUS: rd_mux = {24'h00_0000, status};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // pin synchroniser: readback of pins from outside
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            gp_s1_q <= 4'h0;
            gp_s2_q <= 4'h0;
        end else if (clk_en) begin
            gp_s1_q <= gp_in;
            gp_s2_q <= gp_s1_q;
        end
    end

    // result capture; a fresh result beats a same-cycle read
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            result_q <= '{value: ADCRG_DATA_RST, code: 4'h0};
            nrdy_q <= 1'b1;
        end else if (clk_en) begin
            if (result_valid) begin
                result_q <= '{value: result_value, code: map_code};
                nrdy_q <= 1'b0;
            end else if (rd_data) begin
                nrdy_q <= 1'b1;
            end
        end
    end

    // output control; top bit is held zero whatever the host sends
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            gpo_q <= ADCRG_GPO_RST;
            ctrl_q <= 8'h00;
        end else if (clk_en) begin
            if (wr_gpo) begin
                gpo_q <= {1'b0, reg_wdata[6:0]};
            end
            if (wr_ctrl) begin
                ctrl_q <= reg_wdata[7:0];
            end
        end
    end

    // offsets; calibration wins over a host write in the same cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < ADCRG_NPAIR; i++) begin
                offset_q[i] <= ADCRG_OFFSET_RST;
            end
            offset_sel_q <= 3'h0;
        end else if (clk_en) begin
            if (cal_done) begin
                offset_q[map_pair] <= cal_coeff;
            end else if (wr_off) begin
                offset_q[wr_pair] <= reg_wdata[23:0];
            end
            if (wr_off) begin
                offset_sel_q <= wr_pair;
            end
        end
    end

    // read data one cycle after the strobe; writes to data/id touch nothing
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata_q <= 32'h0000_0000;
        end else if (clk_en) begin
            rdata_q <= reg_rd ? rd_mux : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign reg_rdata = rdata_q;
    assign data_ready_n = nrdy_q;
    assign bridge_switch_on = gpo_q[ADCRG_GPO_BRIDGE];
    // disabled pairs float; their data bits have no effect
    assign gp_oe = {up_en, up_en, lo_en & ~ctrl_q[ADCRG_CTL_REFERENCE_SELECT],
                    lo_en & ~ctrl_q[ADCRG_CTL_REFERENCE_SELECT]};
    assign gp_out = {pair_drive(up_en, gpo_q[3:2]), pair_drive(lo_en, gpo_q[1:0])};
    assign second_reference_input = ctrl_q[ADCRG_CTL_REFERENCE_SELECT];
    assign active_pair = map_pair;
    assign active_offset = offset_q[map_pair];

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_gpo_top_zero: assert property (@(posedge clk) disable iff (reset)
        gpo_q[ADCRG_GPO_TOP] == 1'b0) else $error("output control top bit set");
    a_ready_on_read: assert property (@(posedge clk) disable iff (reset)
        clk_en && rd_data && !result_valid |=> data_ready_n) else $error("ready not set");
    a_result_clears: assert property (@(posedge clk) disable iff (reset)
        clk_en && result_valid |=> !data_ready_n && result_q.value == $past(result_value))
        else $error("result not captured");
    a_upper_drive: assert property (@(posedge clk) disable iff (reset)
        gp_oe[3:2] == {2{gpo_q[ADCRG_GPO_UPEN]}}) else $error("upper enable wrong");
    a_lower_float: assert property (@(posedge clk) disable iff (reset)
        !lo_en |-> gp_oe[1:0] == 2'b00 && gp_out[1:0] == 2'b00) else $error("lower drives");
    a_pin_level: assert property (@(posedge clk) disable iff (reset)
        up_en |-> gp_out[3:2] == gpo_q[3:2]) else $error("pin level wrong");
    a_id_read: assert property (@(posedge clk) disable iff (reset)
        clk_en && reg_rd && reg_addr == ADCRG_SEL_ID |=> reg_rdata == {24'h00_0000, ID_CODE})
        else $error("identity read wrong");
    a_cal_write: assert property (@(posedge clk) disable iff (reset)
        clk_en && cal_done |=> offset_q[$past(map_pair)] == $past(cal_coeff))
        else $error("calibration lost");
    a_status_code: assert property (@(posedge clk) disable iff (reset)
        clk_en && result_valid |=> status[3:0] == $past(map_code)) else $error("code wrong");
    a_bridge: assert property (@(posedge clk) disable iff (reset)
        clk_en && wr_gpo |=> bridge_switch_on == $past(reg_wdata[6])) else $error("bridge");

    // a write aimed at the result register must not disturb it
    a_data_ro_write: assert property (@(posedge clk) disable iff (reset)
        clk_en && reg_wr && reg_addr == ADCRG_SEL_DATA && !result_valid |=>
        result_q == $past(result_q)) else $error("data register written");

    // low seven bits of the output control take the host value
    a_gpo_write: assert property (@(posedge clk) disable iff (reset)
        clk_en && wr_gpo |=> gpo_q[6:0] == $past(reg_wdata[6:0]))
        else $error("output control write lost");

    // the bridge switch only moves on a host write, reset aside
    a_bridge_hold: assert property (@(posedge clk) disable iff (reset)
        clk_en && !wr_gpo |=> bridge_switch_on == $past(bridge_switch_on))
        else $error("bridge moved without write");

    // a disabled upper pair shows nothing of its data bits
    a_upper_float: assert property (@(posedge clk) disable iff (reset)
        !up_en |-> gp_out[3:2] == 2'b00) else $error("upper data leaks");

    // enabled lower pair drives unless taken over as reference
    a_lower_drive: assert property (@(posedge clk) disable iff (reset)
        lo_en && !second_reference_input |-> gp_oe[1:0] == 2'b11)
        else $error("lower not driven");

    // lower pin levels follow their data bits
    a_lower_level: assert property (@(posedge clk) disable iff (reset)
        lo_en |-> gp_out[1:0] == gpo_q[1:0]) else $error("lower level wrong");

    // reference use releases the lower pins
    a_ref_release: assert property (@(posedge clk) disable iff (reset)
        second_reference_input |-> gp_oe[1:0] == 2'b00) else $error("reference pins driven");

    // readback of an enabled pair is the synchronised pin level
    a_upper_readback: assert property (@(posedge clk) disable iff (reset)
        clk_en && reg_rd && reg_addr == ADCRG_SEL_GPO && up_en |=>
        reg_rdata[3:2] == $past(gp_s2_q[3:2])) else $error("upper readback wrong");

    a_lower_readback: assert property (@(posedge clk) disable iff (reset)
        clk_en && reg_rd && reg_addr == ADCRG_SEL_GPO && lo_en |=>
        reg_rdata[1:0] == $past(gp_s2_q[1:0])) else $error("lower readback wrong");

    // without append the top byte of a data read is empty
    a_append_off: assert property (@(posedge clk) disable iff (reset)
        clk_en && rd_data && !ctrl_q[ADCRG_CTL_APPEND] |=>
        reg_rdata == {8'h00, $past(result_q.value)}) else $error("plain data read wrong");

    // with append the status byte follows the result
    a_append_on: assert property (@(posedge clk) disable iff (reset)
        clk_en && rd_data && ctrl_q[ADCRG_CTL_APPEND] |=>
        reg_rdata[31:8] == $past(result_q.value) && reg_rdata[3:0] == $past(result_q.code))
        else $error("appended read wrong");

    // a status read carries the code of the held result
    a_status_read: assert property (@(posedge clk) disable iff (reset)
        clk_en && reg_rd && reg_addr == ADCRG_SEL_STATUS |=>
        reg_rdata[3:0] == $past(result_q.code)) else $error("status code wrong");

    // a host offset write lands in the pair it names
    a_offset_write: assert property (@(posedge clk) disable iff (reset)
        clk_en && wr_off && !cal_done |=> offset_q[$past(wr_pair)] == $past(reg_wdata[23:0]))
        else $error("offset write lost");

    // the readback pointer never leaves the five pairs
    a_offset_sel: assert property (@(posedge clk) disable iff (reset)
        clk_en && wr_off |=> offset_sel_q < 3'(ADCRG_NPAIR)) else $error("pair out of range");

    // pseudo channels four to seven share one pair
    a_pair_shared: assert property (@(posedge clk) disable iff (reset)
        ctrl_q[ADCRG_CTL_PSEUDO] && map_code[3:2] == 2'b01 |-> map_pair == ADCRG_PAIR_SHARED)
        else $error("shared pair wrong");

    // channels zero to three keep their own pair in both modes
    a_pair_direct: assert property (@(posedge clk) disable iff (reset)
        map_code[3:2] == 2'b00 |-> map_pair == {1'b0, map_code[1:0]})
        else $error("direct pair wrong");

    a_short_pair: assert property (@(posedge clk) disable iff (reset)
        map_code == ADCRG_CODE_SHORT |-> map_pair == 3'h0) else $error("short pair wrong");

    // temperature and short enables report their fixed codes
    a_temp_code: assert property (@(posedge clk) disable iff (reset)
        chan_en == 10'(1 << ADCRG_TEMP_BIT) |-> map_code == ADCRG_CODE_TEMP)
        else $error("temperature code wrong");

    a_short_code: assert property (@(posedge clk) disable iff (reset)
        chan_en == 10'(1 << ADCRG_SHORT_BIT) |-> map_code == ADCRG_CODE_SHORT)
        else $error("short code wrong");

    // clock enable low holds every register
    a_clken_freeze: assert property (@(posedge clk) disable iff (reset)
        !clk_en |=> gpo_q == $past(gpo_q) && nrdy_q == $past(nrdy_q) &&
        rdata_q == $past(rdata_q)) else $error("state moved while frozen");

    // read data stand only in the cycle after a read strobe
    a_idle_rdata: assert property (@(posedge clk) disable iff (reset)
        clk_en && !reg_rd |=> reg_rdata == 32'h0000_0000) else $error("stale read data");
endmodule : adcrg_regs
`default_nettype wire

// ==== pkg/adcrg_pkg.sv ====
// package: register map, field layout and carrier types of the converter register bank
`default_nettype none
package adcrg_pkg;
    // register select codes
    localparam logic [2:0] ADCRG_SEL_DATA = 3'h3;
    localparam logic [2:0] ADCRG_SEL_ID = 3'h4;
    localparam logic [2:0] ADCRG_SEL_GPO = 3'h5;
    localparam logic [2:0] ADCRG_SEL_OFFSET = 3'h6;
    // register select codes of my own for loose control and status
    localparam logic [2:0] ADCRG_SEL_CTRL = 3'h1;
    localparam logic [2:0] ADCRG_SEL_STATUS = 3'h0;
    // widths
    localparam int ADCRG_DW = 24;
    localparam int ADCRG_NPAIR = 5;
    // reset values
    localparam logic [23:0] ADCRG_DATA_RST = 24'h00_0000;
    localparam logic [23:0] ADCRG_OFFSET_RST = 24'h80_0000;
    localparam logic [7:0] ADCRG_GPO_RST = 8'h00;
    // output control field positions
    localparam int ADCRG_GPO_TOP = 7;
    localparam int ADCRG_GPO_BRIDGE = 6;
    localparam int ADCRG_GPO_UPEN = 5;
    localparam int ADCRG_GPO_LOEN = 4;
    // control register field positions
    localparam int ADCRG_CTL_APPEND = 0;
    localparam int ADCRG_CTL_REFERENCE_SELECT = 1;
    localparam int ADCRG_CTL_PSEUDO = 2;
    // status field positions
    localparam int ADCRG_STA_NRDY = 7;
    // channel codes
    localparam logic [3:0] ADCRG_CODE_TEMP = 4'h8;
    localparam logic [3:0] ADCRG_CODE_SHORT = 4'h9;
    localparam logic [2:0] ADCRG_PAIR_SHARED = 3'h4;
    localparam int ADCRG_TEMP_BIT = 8;
    localparam int ADCRG_SHORT_BIT = 9;
    // converter result carrier
    typedef struct packed {
        logic [23:0] value;
        logic [3:0] code;
    } adcrg_result_t;
    // calibration carrier
    typedef struct packed {
        logic [2:0] pair;
        logic [23:0] coeff;
    } adcrg_cal_t;
endpackage : adcrg_pkg
`default_nettype wire
